/* rtl/mdio_top.sv */
`timescale 1ns/100ps
//
// Contract
// - Single-chip port 2 direction bit selects output
// - Port 2 pull-up: select set, direction clear
// - Reset, hardware standby kill pull-ups; software keeps
// - Modes 1, 3 never pull up
// - Expanded modes: port 3 is data bus
// - Single-chip port 3 direction bit selects output
// - Port 3 direction write-only, reads all ones
// - Port 3 direction clears; software standby keeps
// - Software standby keeps driven outputs steady
// - Data read: latch if output, else pin
// - Port 3 latch readable, clears, software standby keeps
// - Modes 1, 3: port 5 drives address high
// - Mode 5: port 5 address or input
// - Single-chip port 5 is per-pin I/O
// - Port 5 direction resets upper ones, lower zeros
// - Port 5 latch upper bits fixed ones
// - Port 5 pull-up: select set, direction clear
module mdio_top (
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    input  wire logic                          ce,
    // Mode straps and standby controls
    input  wire logic [2:0]                    mode_pins,
    input  wire logic                          hw_standby_b,
    input  wire logic                          sw_standby,
    // Register port
    input  wire logic [mdio_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [mdio_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [mdio_pkg::DATA_W-1:0]   reg_rdata,
    // Expanded-mode signals to and from the bus controller
    input  wire logic [mdio_pkg::P2_W-1:0]     addr_mid,
    input  wire logic [mdio_pkg::P5_W-1:0]     addr_high,
    input  wire logic [mdio_pkg::P3_W-1:0]     bus_data_out,
    input  wire logic                          bus_data_oe,
    output logic      [mdio_pkg::P3_W-1:0]     bus_data_in,
    // Port 2 pins
    input  wire logic [mdio_pkg::P2_W-1:0]     p2_in,
    output logic      [mdio_pkg::P2_W-1:0]     p2_out,
    output logic      [mdio_pkg::P2_W-1:0]     p2_oe,
    output logic      [mdio_pkg::P2_W-1:0]     p2_pullup,
    // Port 3 pins
    input  wire logic [mdio_pkg::P3_W-1:0]     p3_in,
    output logic      [mdio_pkg::P3_W-1:0]     p3_out,
    output logic      [mdio_pkg::P3_W-1:0]     p3_oe,
    // Port 5 pins
    input  wire logic [mdio_pkg::P5_W-1:0]     p5_in,
    output logic      [mdio_pkg::P5_W-1:0]     p5_out,
    output logic      [mdio_pkg::P5_W-1:0]     p5_oe,
    output logic      [mdio_pkg::P5_W-1:0]     p5_pullup
);

    localparam int unsigned SYNC_W =
        mdio_pkg::P2_W + mdio_pkg::P3_W + mdio_pkg::P5_W + 3 + 1;

    // Synchronised pin levels
    logic [SYNC_W-1:0]           sync_raw;
    logic [SYNC_W-1:0]           sync_val;
    logic [mdio_pkg::P2_W-1:0]   p2_sync;
    logic [mdio_pkg::P3_W-1:0]   p3_sync;
    logic [mdio_pkg::P5_W-1:0]   p5_sync;
    logic [2:0]                  mode_sync;
    logic                        hw_stby;

    // Software-visible registers
    logic [7:0]                  second_port_direction_bits;
    logic [7:0]                  second_port_latch_bits;
    logic [7:0]                  second_port_pullup_bits;
    logic [7:0]                  port3_direction;
    logic [7:0]                  port3_output_latch;
    logic [7:0]                  port5_direction;
    logic [7:0]                  port5_output_latch;
    logic [7:0]                  port5_pullup_select;

    // Mode decode
    mdio_pkg::mdio_mode_e        mode;
    logic                        mode_rom_off;
    logic                        mode_rom_on;
    logic                        mode_expanded;
    logic                        pull_allowed;

    // Register decode
    logic                        hit_p2_dir;
    logic                        hit_p2_latch;
    logic                        hit_p2_pull;
    logic                        hit_p3_dir;
    logic                        hit_p3_latch;
    logic                        hit_p5_dir;
    logic                        hit_p5_latch;
    logic                        hit_p5_pull;
    logic [7:0]                  next_rdata;

    // Owner selects and read values per port
    logic [mdio_pkg::P2_W-1:0]   p2_alt_sel;
    logic [mdio_pkg::P3_W-1:0]   p3_alt_sel;
    logic [mdio_pkg::P5_W-1:0]   p5_alt_sel;
    logic [mdio_pkg::P2_W-1:0]   p2_read;
    logic [mdio_pkg::P3_W-1:0]   p3_read;
    logic [mdio_pkg::P5_W-1:0]   p5_read;

    // All pin-side inputs cross through one synchroniser
    assign sync_raw = {p2_in, p3_in, p5_in, mode_pins, ~hw_standby_b};

    mdio_sync #(
        .W (SYNC_W)
    ) u_sync (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .ce       (ce),
        .async_in (sync_raw),
        .sync_out (sync_val)
    );

    // Split the synchronised word back into its fields
    assign hw_stby   = sync_val[0];
    assign mode_sync = sync_val[3:1];
    assign p5_sync   = sync_val[4 +: mdio_pkg::P5_W];
    assign p3_sync   = sync_val[4 + mdio_pkg::P5_W +: mdio_pkg::P3_W];
    assign p2_sync   = sync_val[4 + mdio_pkg::P5_W + mdio_pkg::P3_W +:
                                mdio_pkg::P2_W];

    // Undefined mode codes fall back to single-chip behaviour
    assign mode          = mdio_pkg::mdio_mode_e'(mode_sync);
    assign mode_rom_off  = (mode == mdio_pkg::MDIO_MODE1) ||
                           (mode == mdio_pkg::MDIO_MODE3);
    assign mode_rom_on   = (mode == mdio_pkg::MDIO_MODE5);
    assign mode_expanded = mode_rom_off || mode_rom_on;
    // no pull-ups in modes 1, 3
    assign pull_allowed  = !mode_rom_off;

    // Address decode shared by writes and reads
    assign hit_p2_dir   = mdio_pkg::mdio_hit(reg_addr, mdio_pkg::OFS_P2_DIR);
    assign hit_p2_latch = mdio_pkg::mdio_hit(reg_addr,
                                             mdio_pkg::OFS_P2_LATCH);
    assign hit_p2_pull  = mdio_pkg::mdio_hit(reg_addr, mdio_pkg::OFS_P2_PULL);
    assign hit_p3_dir   = mdio_pkg::mdio_hit(reg_addr, mdio_pkg::OFS_P3_DIR);
    assign hit_p3_latch = mdio_pkg::mdio_hit(reg_addr,
                                             mdio_pkg::OFS_P3_LATCH);
    assign hit_p5_dir   = mdio_pkg::mdio_hit(reg_addr, mdio_pkg::OFS_P5_DIR);
    assign hit_p5_latch = mdio_pkg::mdio_hit(reg_addr,
                                             mdio_pkg::OFS_P5_LATCH);
    assign hit_p5_pull  = mdio_pkg::mdio_hit(reg_addr, mdio_pkg::OFS_P5_PULL);

    // Port 2 register writes; hardware standby acts like reset
    // pull-up select cleared by hardware standby
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            second_port_direction_bits <= mdio_pkg::RST_P2_DIR;
            second_port_latch_bits     <= mdio_pkg::RST_P2_LATCH;
            second_port_pullup_bits    <= mdio_pkg::RST_P2_PULL;
        end else if (ce) begin
            if (hw_stby) begin
                second_port_direction_bits <= mdio_pkg::RST_P2_DIR;
                second_port_latch_bits     <= mdio_pkg::RST_P2_LATCH;
                second_port_pullup_bits    <= mdio_pkg::RST_P2_PULL;
            end else if (reg_wr) begin
                if (hit_p2_dir) begin
                    second_port_direction_bits <= reg_wdata;
                end
                if (hit_p2_latch) begin
                    second_port_latch_bits <= reg_wdata;
                end
                if (hit_p2_pull) begin
                    second_port_pullup_bits <= reg_wdata;
                end
            end
        end
    end

    // Port 3 register writes
    // direction clears, software standby retains
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            port3_direction    <= mdio_pkg::RST_P3_DIR;
            port3_output_latch <= mdio_pkg::RST_P3_LATCH;
        end else if (ce) begin
            if (hw_stby) begin
                port3_direction    <= mdio_pkg::RST_P3_DIR;
                port3_output_latch <= mdio_pkg::RST_P3_LATCH;
            end else if (reg_wr) begin
                if (hit_p3_dir) begin
                    port3_direction <= reg_wdata;
                end
                if (hit_p3_latch) begin
                    port3_output_latch <= reg_wdata;
                end
            end
        end
    end

    // Port 5 register writes; upper nibbles are fixed ones
    // direction resets with upper ones
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            port5_direction     <= mdio_pkg::RST_P5_DIR;
            port5_output_latch  <= mdio_pkg::RST_P5_LATCH;
            port5_pullup_select <= mdio_pkg::RST_P5_PULL;
        end else if (ce) begin
            if (hw_stby) begin
                port5_direction     <= mdio_pkg::RST_P5_DIR;
                port5_output_latch  <= mdio_pkg::RST_P5_LATCH;
                port5_pullup_select <= mdio_pkg::RST_P5_PULL;
            end else if (reg_wr) begin
                if (hit_p5_dir) begin
                    port5_direction <= {mdio_pkg::P5_RSV_BITS,
                                        reg_wdata[3:0]};
                end
                if (hit_p5_latch) begin
                    port5_output_latch <= {mdio_pkg::P5_RSV_BITS,
                                           reg_wdata[3:0]};
                end
                if (hit_p5_pull) begin
                    port5_pullup_select <= {mdio_pkg::P5_RSV_BITS,
                                            reg_wdata[3:0]};
                end
            end
        end
    end

    // Who owns each pin in the current mode
    // single-chip port 2 left to direction
    assign p2_alt_sel = mode_rom_off ? {mdio_pkg::P2_W{1'b1}} :
                        mode_rom_on  ? second_port_direction_bits :
                                       {mdio_pkg::P2_W{1'b0}};
    // expanded modes hand port 3 to bus
    // single-chip port 3 left to direction
    assign p3_alt_sel = mode_expanded ? {mdio_pkg::P3_W{1'b1}} :
                                        {mdio_pkg::P3_W{1'b0}};
    // modes 1, 3 force address out
    // single-chip port 5 is plain I/O
    assign p5_alt_sel = mode_rom_off ? {mdio_pkg::P5_W{1'b1}} :
                        mode_rom_on  ? port5_direction[3:0] :
                                       {mdio_pkg::P5_W{1'b0}};

    // Data bus input sampled straight from the synchronised pins
    assign bus_data_in = p3_sync;

    mdio_pin_cell #(
        .W (mdio_pkg::P2_W)
    ) u_port2 (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .ce       (ce),
        .hold     (sw_standby),
        .off      (hw_stby),
        .alt_sel  (p2_alt_sel),
        .alt_data (addr_mid),
        .alt_oe   ({mdio_pkg::P2_W{1'b1}}),
        .dir      (second_port_direction_bits),
        .latch    (second_port_latch_bits),
        .pin_sync (p2_sync),
        .pull_en  (pull_allowed),
        .pull_sel (second_port_pullup_bits),
        .pin_out  (p2_out),
        .pin_oe   (p2_oe),
        .pull_on  (p2_pullup),
        .read_val (p2_read)
    );

    // Port 3 has no pull-ups; its cell pull output is left open
    // direction ignored while bus owns pins
    mdio_pin_cell #(
        .W (mdio_pkg::P3_W)
    ) u_port3 (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .ce       (ce),
        .hold     (sw_standby),
        .off      (hw_stby),
        .alt_sel  (p3_alt_sel),
        .alt_data (bus_data_out),
        .alt_oe   ({mdio_pkg::P3_W{bus_data_oe}}),
        .dir      (port3_direction),
        .latch    (port3_output_latch),
        .pin_sync (p3_sync),
        .pull_en  (1'b0),
        .pull_sel ({mdio_pkg::P3_W{1'b0}}),
        .pin_out  (p3_out),
        .pin_oe   (p3_oe),
        .pull_on  (),
        .read_val (p3_read)
    );

    // port 5 pull-up on input only
    mdio_pin_cell #(
        .W (mdio_pkg::P5_W)
    ) u_port5 (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .ce       (ce),
        .hold     (sw_standby),
        .off      (hw_stby),
        .alt_sel  (p5_alt_sel),
        .alt_data (addr_high),
        .alt_oe   ({mdio_pkg::P5_W{1'b1}}),
        .dir      (port5_direction[3:0]),
        .latch    (port5_output_latch[3:0]),
        .pin_sync (p5_sync),
        .pull_en  (pull_allowed),
        .pull_sel (port5_pullup_select[3:0]),
        .pin_out  (p5_out),
        .pin_oe   (p5_oe),
        .pull_on  (p5_pullup),
        .read_val (p5_read)
    );

    // Read selection; unmapped addresses answer zero
    // direction registers read as ones
    assign next_rdata =
        (hit_p2_dir || hit_p3_dir || hit_p5_dir) ? mdio_pkg::READ_WO :
        hit_p2_latch ? p2_read :
        hit_p2_pull  ? second_port_pullup_bits :
        hit_p3_latch ? p3_read :
        hit_p5_latch ? {mdio_pkg::P5_RSV_BITS, p5_read} :
        hit_p5_pull  ? port5_pullup_select :
                       mdio_pkg::READ_UNMAP;

    // Read data valid the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= mdio_pkg::READ_UNMAP;
        end else if (ce && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // mdio_top

/* rtl/mdio_pkg.sv */
package mdio_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;

    // Port widths as seen on the pins
    localparam int unsigned P2_W = 8;
    localparam int unsigned P3_W = 8;
    localparam int unsigned P5_W = 4;

    // Register offsets, lower 16 bits of the address
    localparam logic [15:0] OFS_P2_DIR   = 16'hFFC1;
    localparam logic [15:0] OFS_P2_LATCH = 16'hFFC3;
    localparam logic [15:0] OFS_P3_DIR   = 16'hFFC4;
    localparam logic [15:0] OFS_P3_LATCH = 16'hFFC6;
    localparam logic [15:0] OFS_P5_DIR   = 16'hFFC8;
    localparam logic [15:0] OFS_P5_LATCH = 16'hFFCA;
    localparam logic [15:0] OFS_P2_PULL  = 16'hFFD8;
    localparam logic [15:0] OFS_P5_PULL  = 16'hFFDB;

    // Reset values
    localparam logic [7:0] RST_P2_DIR   = 8'h00;
    localparam logic [7:0] RST_P2_LATCH = 8'h00;
    localparam logic [7:0] RST_P2_PULL  = 8'h00;
    localparam logic [7:0] RST_P3_DIR   = 8'h00;
    localparam logic [7:0] RST_P3_LATCH = 8'h00;
    localparam logic [7:0] RST_P5_DIR   = 8'hF0;
    localparam logic [7:0] RST_P5_LATCH = 8'hF0;
    localparam logic [7:0] RST_P5_PULL  = 8'hF0;

    // Fixed read values
    localparam logic [7:0] READ_WO      = 8'hFF;
    localparam logic [3:0] P5_RSV_BITS  = 4'hF;
    localparam logic [7:0] READ_UNMAP   = 8'h00;

    // Operating modes on the mode pins
    typedef enum logic [2:0] {
        MDIO_MODE0 = 3'h0,
        MDIO_MODE1 = 3'h1,
        MDIO_MODE2 = 3'h2,
        MDIO_MODE3 = 3'h3,
        MDIO_MODE4 = 3'h4,
        MDIO_MODE5 = 3'h5,
        MDIO_MODE6 = 3'h6,
        MDIO_MODE7 = 3'h7
    } mdio_mode_e;

    // Address match used by every register decode
    function automatic logic mdio_hit(input logic [15:0] addr,
                                      input logic [15:0] ofs);
        mdio_hit = (addr == ofs);
    endfunction

endpackage

/* rtl/mdio_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for pin inputs, frozen while ce is low
module mdio_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;

    // Elaboration-time guard on the width
    if (W < 1) begin : g_bad_w
        $error("mdio_sync: width must be at least one");
    end

    // First stage is read only by the second stage
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // mdio_sync

/* rtl/mdio_pin_cell.sv */
`timescale 1ns/100ps
// Per-port pin driver: owner select, output/enable/pull-up flops, read mux
module mdio_pin_cell #(
    parameter int unsigned W = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic         hold,
    input  wire logic         off,
    input  wire logic [W-1:0] alt_sel,
    input  wire logic [W-1:0] alt_data,
    input  wire logic [W-1:0] alt_oe,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] pin_sync,
    input  wire logic         pull_en,
    input  wire logic [W-1:0] pull_sel,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe,
    output logic      [W-1:0] pull_on,
    output logic      [W-1:0] read_val
);

    logic [W-1:0] next_out;
    logic [W-1:0] next_oe;
    logic [W-1:0] next_pull;

    // Elaboration-time guard; one register byte serves at most 8 pins
    if (W < 1 || W > 8) begin : g_bad_w
        $error("mdio_pin_cell: width must be 1 to 8");
    end

    // External function owns a pin, otherwise direction bit decides
    assign next_out  = (alt_sel & alt_data) | (~alt_sel & latch);
    assign next_oe   = (alt_sel & alt_oe) | (~alt_sel & dir);
    // pull-up needs select set, input pin
    assign next_pull = {W{pull_en}} & pull_sel & ~dir & ~alt_sel;
    // read returns latch or pin level
    assign read_val  = (dir & latch) | (~dir & pin_sync);

    // Hold keeps pins steady through software standby
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= '0;
            pin_oe  <= '0;
            pull_on <= '0;
        end else if (ce) begin
            if (off) begin
                pin_out <= '0;
                pin_oe  <= '0;
                pull_on <= '0;
            end else if (!hold) begin
                pin_out <= next_out;
                pin_oe  <= next_oe;
                pull_on <= next_pull;
            end
        end
    end

endmodule // mdio_pin_cell

/* sim/mdio_top_sva.sv */
`timescale 1ns/100ps
// Port-level checks on pin drive, pull-ups and register reads
module mdio_top_sva (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [2:0]  mode_pins,
    input wire logic        hw_standby_b,
    input wire logic        sw_standby,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [3:0]  addr_high,
    input wire logic        bus_data_oe,
    input wire logic [7:0]  p2_oe,
    input wire logic [7:0]  p2_pullup,
    input wire logic [7:0]  p3_out,
    input wire logic [7:0]  p3_oe,
    input wire logic [3:0]  p5_out,
    input wire logic [3:0]  p5_oe,
    input wire logic [3:0]  p5_pullup
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // Mode and standby need six steady edges: two sync flops plus slack
    p2_pull_a: assert property ((p2_pullup & p2_oe) == 8'h00)
        else $error("port 2 pull-up on a driven pin");
    p5_pull_a: assert property ((p5_pullup & p5_oe) == 4'h0)
        else $error("port 5 pull-up on a driven pin");
    hw_stby_a: assert property ((!hw_standby_b)[*6] |->
        p2_pullup == 8'h00 && p3_oe == 8'h00 && p5_pullup == 4'h0)
        else $error("hardware standby left a pin active");
    sw_hold_a: assert property (sw_standby && $past(sw_standby)
        && hw_standby_b |-> $stable(p3_out) && $stable(p3_oe)
        && $stable(p5_oe) && $stable(p2_pullup))
        else $error("pin changed in software standby");
    rd_wo_a: assert property (reg_rd && reg_addr == 16'hFFC4
        |=> reg_rdata == 8'hFF)
        else $error("write-only direction not read as ones");
    p5_rsv_a: assert property (reg_rd && reg_addr == 16'hFFCA
        |=> reg_rdata[7:4] == 4'hF)
        else $error("port 5 upper bits not ones");
    p5_addr_a: assert property ((mode_pins == 3'h1 && hw_standby_b
        && !sw_standby)[*6] |-> p5_oe == 4'hF && p5_out == $past(addr_high))
        else $error("port 5 not driving high address");
    exp_pull_a: assert property ((mode_pins == 3'h1
        || mode_pins == 3'h3)[*6] |-> p2_pullup == 8'h00 && p5_pullup == 4'h0)
        else $error("pull-up on in expanded mode");
    bus_oe_a: assert property (((mode_pins == 3'h1 || mode_pins == 3'h3
        || mode_pins == 3'h5) && hw_standby_b && !sw_standby)[*6]
        |-> p3_oe == {8{$past(bus_data_oe)}})
        else $error("port 3 not following bus drive");
    rst_pins_a: assert property ($rose(rst_b) |-> p3_oe == 8'h00
        && p5_oe == 4'h0 && p2_pullup == 8'h00)
        else $error("pins active at reset release");
endmodule // mdio_top_sva

bind mdio_top mdio_top_sva i_sva (.mclk, .rst_b, .mode_pins, .hw_standby_b,
    .sw_standby, .reg_addr, .reg_rd, .reg_rdata, .addr_high, .bus_data_oe,
    .p2_oe, .p2_pullup, .p3_out, .p3_oe, .p5_out, .p5_oe, .p5_pullup);

/* sim/mdio_pins.sv */
`timescale 1ns/100ps
// Board model of ports 3 and 5: device drive wins over outside drive
module mdio_pins (
    input  wire logic       mclk,
    input  wire logic [7:0] p3_out,
    input  wire logic [7:0] p3_oe,
    input  wire logic [7:0] p3_ext,
    input  wire logic [7:0] p3_ext_en,
    input  wire logic [3:0] p5_out,
    input  wire logic [3:0] p5_oe,
    input  wire logic [3:0] p5_pullup,
    input  wire logic [3:0] p5_ext,
    input  wire logic [3:0] p5_ext_en,
    output logic      [7:0] p3_in,
    output logic      [3:0] p5_in
);
    logic toggle = 1'b0;

    // Floating lines wander so a stale level never reads as valid
    always_ff @(posedge mclk) toggle <= ~toggle;
    assign p3_in = (p3_oe & p3_out) | (~p3_oe & p3_ext_en & p3_ext)
                 | (~p3_oe & ~p3_ext_en & {8{toggle}});
    assign p5_in = (p5_oe & p5_out) | (~p5_oe & p5_ext_en & p5_ext)
                 | (~p5_oe & ~p5_ext_en & (p5_pullup | {4{toggle}}));
endmodule // mdio_pins

/* sim/mode_dependent_io_ports_bench.sv */
`timescale 1ns/100ps
// Self-checking bench for the port block
module mode_dependent_io_ports_bench;
    logic        mclk, rst_b, ce, hw_standby_b, sw_standby, reg_wr, reg_rd;
    logic        bus_data_oe;
    logic [2:0]  mode_pins;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, addr_mid, bus_data_out, got;
    logic [7:0]  p2_in, p2_out, p2_oe, p2_pullup, p3_in, p3_out, p3_oe;
    logic [7:0]  p3_ext, p3_ext_en, bus_data_in;
    logic [3:0]  addr_high, p5_in, p5_out, p5_oe, p5_pullup, p5_ext;
    logic [3:0]  p5_ext_en;
    int          bad_count = 0;
    int          total_checks = 0;

    mdio_top i_dut (.mclk, .rst_b, .ce, .mode_pins, .hw_standby_b,
        .sw_standby, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .addr_mid, .addr_high, .bus_data_out, .bus_data_oe, .bus_data_in,
        .p2_in, .p2_out, .p2_oe, .p2_pullup, .p3_in, .p3_out, .p3_oe,
        .p5_in, .p5_out, .p5_oe, .p5_pullup);
    mdio_pins i_pins (.mclk, .p3_out, .p3_oe, .p3_ext, .p3_ext_en, .p5_out,
        .p5_oe, .p5_pullup, .p5_ext, .p5_ext_en, .p3_in, .p5_in);

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Write strobe is dropped for a cycle so no signal moves twice at once
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [15:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        got = reg_rdata;
    endtask

    // Mode straps are settled while reset is held
    task automatic rst(input logic [2:0] m);
        rst_b <= 1'b0;
        mode_pins <= m;
        pause(4);
        rst_b <= 1'b1;
        pause(4);
    endtask

    task automatic t_single(input logic [2:0] m);
        rst(m);
        p3_ext <= 8'h3C;
        p3_ext_en <= 8'hFF;
        p5_ext_en <= 4'h0;
        rd(16'hFFC4); chk("p3 dir read", 8'hFF, got);
        rd(16'hFFC0); chk("unmapped", 8'h00, got);
        rd(16'hFFDB); chk("p5 pull reset", 8'hF0, got);
        wr(16'hFFC6, 8'h5A);
        wr(16'hFFC4, 8'h0F);
        wr(16'hFFDB, 8'h0F);
        wr(16'hFFC8, 8'h03);
        wr(16'hFFCA, 8'h05);
        wr(16'hFFC1, 8'hF0);
        wr(16'hFFC3, 8'h3C);
        wr(16'hFFD8, 8'hFF);
        pause(2);
        chk("p3_oe", 8'h0F, p3_oe);
        chk("p3_out", 8'h0A, {4'h0, p3_out[3:0]});
        rd(16'hFFC6); chk("p3 read", 8'h3A, got);
        rd(16'hFFCA); chk("p5 read", 8'hFD, got);
        chk("p5_oe", 8'h03, {4'h0, p5_oe});
        chk("p5_out", 8'h01, {6'h00, p5_out[1:0]});
        chk("p5_pullup", 8'h0C, {4'h0, p5_pullup});
        chk("p2_oe", 8'hF0, p2_oe);
        chk("p2_pullup", 8'h0F, p2_pullup);
        chk("p2_out", 8'h3C, p2_out);
        rd(16'hFFC3); chk("p2 read", 8'h30, got);
        // Outputs must hold while software standby is in force
        sw_standby <= 1'b1;
        pause(1);
        wr(16'hFFC6, 8'h00);
        pause(3);
        chk("p3_out held", 8'h0A, {4'h0, p3_out[3:0]});
        chk("pull held", 8'h0F, p2_pullup);
        sw_standby <= 1'b0;
        pause(3);
        chk("p3_out new", 8'h00, {4'h0, p3_out[3:0]});
        hw_standby_b <= 1'b0;
        p5_ext <= 4'h6;
        p5_ext_en <= 4'hF;
        pause(6);
        chk("hw p3_oe", 8'h00, p3_oe);
        chk("hw pull", 8'h00, p2_pullup);
        hw_standby_b <= 1'b1;
        pause(4);
        rd(16'hFFCA); chk("p5 after hw", 8'hF6, got);
        wr(16'hFFC4, 8'hFF);
        pause(2);
        rd(16'hFFC6); chk("p3 latch hw", 8'h00, got);
    endtask

    task automatic t_exp(input logic [2:0] m);
        rst(m);
        addr_high <= 4'h9;
        bus_data_out <= 8'hC3;
        bus_data_oe <= 1'b0;
        wr(16'hFFC4, 8'hFF);
        wr(16'hFFD8, 8'hFF);
        wr(16'hFFC8, 8'h05);
        pause(3);
        chk("exp p3_oe", 8'h00, p3_oe);
        chk("exp p5_oe", (m == 3'h5) ? 8'h05 : 8'h0F, {4'h0, p5_oe});
        chk("exp p5_out", (m == 3'h5) ? 8'h01 : 8'h09,
            {4'h0, p5_out});
        chk("bus in", 8'h3C, bus_data_in);
        chk("exp pull", (m == 3'h5) ? 8'hFF : 8'h00, p2_pullup);
        bus_data_oe <= 1'b1;
        pause(3);
        chk("bus oe", 8'hFF, p3_oe);
        chk("bus out", 8'hC3, p3_out);
        // Clock enable low must swallow a register write
        ce <= 1'b0;
        wr(16'hFFC8, 8'h0A);
        ce <= 1'b1;
        pause(3);
        chk("ce hold", (m == 3'h5) ? 8'h05 : 8'h0F, {4'h0, p5_oe});
        chk("bus in oe", 8'hC3, bus_data_in);
    endtask

    // Hang guard, far beyond the few hundred cycles of the run
    initial begin
        pause(20000);
        bad_count++;
        test_done();
    end

    initial begin
        {rst_b, reg_wr, reg_rd, sw_standby, bus_data_oe} = 5'h00;
        {ce, hw_standby_b} = 2'h3;
        {mode_pins, reg_addr, reg_wdata} = 27'h0000000;
        {addr_mid, bus_data_out, p2_in, p3_ext, p3_ext_en} = 40'h0000000000;
        {addr_high, p5_ext, p5_ext_en} = 12'h000;
        t_single(3'h6);
        t_single(3'h7);
        t_exp(3'h1);
        t_exp(3'h3);
        t_exp(3'h5);
        test_done();
    end
endmodule // mode_dependent_io_ports_bench
